// *** logic/serial_follower_pkg.sv ***
`default_nettype none
package serial_follower_pkg;

  // System clock and character framing.
  localparam int CLK_HZ = 250_000_000;
  localparam int DATA_BITS = 8;
  localparam int CHAR_BITS = 11;

  // Telegram framing values.
  localparam logic [7:0] FRAME_START_CHAR = 8'h02;
  localparam logic [7:0] LEN_OVERHEAD = 8'h02;
  localparam int ADDR_FMT_BIT = 7;
  localparam logic [6:0] BCAST_NODE = 7'h00;

  // The minimum baud rate sets the width of the bit-time divider.
  localparam int BAUD_MIN = 2400;
  localparam int BAUD_MAX = 115200;
  localparam int DIV_MAX = CLK_HZ / BAUD_MIN;
  localparam int DIV_W = $clog2(DIV_MAX + 1);

  // Response data buffer shape.
  localparam int FIFO_WIDTH = 8;
  localparam int FIFO_DEPTH = 16;

  // Values held after reset.
  localparam logic [2:0] LINE_SYNC_RST = 3'h7;
  localparam logic [11:0] TX_IDLE_CHAR = 12'hFFF;

  typedef enum logic [1:0] {PAR_EVEN, PAR_ODD, PAR_NONE} par_mode_t;

  // Configuration; delays are counted in bit times.
  typedef struct packed {
    logic [DIV_W-1:0] baud_div;
    logic [6:0] node;
    par_mode_t par;
    logic stop2;
    logic [15:0] min_dly;
    logic [15:0] max_dly;
  } cfg_t;

  // One-cycle event pulses for status reporting.
  typedef struct packed {
    logic frame_ok;
    logic bcast;
    logic par_err;
    logic frm_err;
    logic len_err;
    logic bcc_err;
    logic resp_sent;
    logic resp_missed;
  } stat_t;

  // Parity bit that makes the ones count even (or odd) over data and it.
  function automatic logic par_bit(input logic [7:0] d, input par_mode_t m);
    return (^d) ^ (m == PAR_ODD);
  endfunction

endpackage
`default_nettype wire

// *** logic/byte_fifo.sv ***
`timescale 1ns/1ps
`default_nettype none
module byte_fifo
  import serial_follower_pkg::*;
#(
  parameter int WIDTH = FIFO_WIDTH,
  parameter int DEPTH = FIFO_DEPTH
) (
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic [WIDTH-1:0] in_data_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  output logic [WIDTH-1:0] out_data_o,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [$clog2(DEPTH):0] count_o
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_d;
  logic push;
  logic pop;

  // Transfers happen only when both sides agree.
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;
  assign out_data_o = mem_q[rd_q];

  // Next fill level.
  always_comb begin
    cnt_d = count_o;
    if (push && !pop) begin
      cnt_d = count_o + 1'b1;
    end else if (pop && !push) begin
      cnt_d = count_o - 1'b1;
    end
  end

  // Storage has no reset; only the words below the fill level are read.
  always_ff @(posedge mclk_i) begin
    if (push) begin
      mem_q[wr_q] <= in_data_i;
    end
  end

  // Pointers wrap naturally since the depth is a power of two.
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
    end
  end

  // Registered level and flags keep both handshakes glitch free.
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      count_o <= '0;
      in_ready_o <= 1'b1;
      out_valid_o <= 1'b0;
    end else begin
      count_o <= cnt_d;
      in_ready_o <= (cnt_d != FULL);
      out_valid_o <= (cnt_d != '0);
    end
  end

  property p_no_overflow;
    @(posedge mclk_i) disable iff (!rst_b_i)
    (count_o == FULL) |-> !in_ready_o;
  endproperty
  a_no_overflow: assert property (p_no_overflow)
    else $error("fifo accepts data while full");

endmodule
`default_nettype wire

// *** logic/serial_follower.sv ***
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// RQ1: Start, eight data, parity, stop bits.
// RQ2: Parity makes ones count even.
// RQ3: Telegram starts with start character.
// RQ4: Order start, length, address, data, check.
// RQ5: Length equals data bytes plus two.
// RQ6: Variable text lengths are accepted.
// RQ7: Address bit seven selects format.
// RQ8: Low seven bits node; zero broadcasts.
// RQ9: Response copies received address byte.
// RQ10: Transmit only after own addressed request.
// RQ11: Drive line only while responding.
// RQ12: One master polls up to 126.
// RQ13: Short, long and text telegrams supported.
// RQ14: Baud, parity, stop bits, node configurable.
// RQ15: Wait minimum delay before responding.
// RQ16: Response dropped after maximum delay.
// RQ17: Check byte is XOR of bytes.
// RQ18: Process block passes through unchanged.
// RQ19: Ignore other addresses; broadcasts get silence.
// RQ20: Discard and flag parity or check errors; data bytes leave on rx_vld_o before the check byte is tested.
module serial_follower
  import serial_follower_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire cfg_t cfg_i,
  input wire logic line_rx_i,
  output logic line_tx_o,
  output logic line_oe_b_o,
  output logic [7:0] rx_data_o,
  output logic rx_vld_o,
  output logic [7:0] rx_addr_o,
  output stat_t stat_o,
  input wire logic [7:0] resp_len_i,
  input wire logic [7:0] tx_data_i,
  input wire logic tx_vld_i,
  output logic tx_rdy_o
);
  typedef enum logic [1:0] {C_IDLE, C_START, C_BITS, C_STOP} rxc_state_t;
  typedef enum logic [2:0] {F_HUNT, F_LEN, F_ADDR, F_DATA, F_BCC} frm_state_t;
  typedef enum logic [2:0] {
    T_IDLE, T_WAIT, T_STX, T_LEN, T_ADR, T_DAT, T_BCC, T_DRAIN
  } tx_state_t;

  logic [2:0] rx_s_q;
  logic rx_q;
  logic [DIV_W-1:0] bt_cnt_q;
  logic tick;
  rxc_state_t rc_st_q;
  logic [DIV_W-1:0] rc_cnt_q;
  logic [3:0] rc_bit_q;
  logic [8:0] rc_sh_q;
  logic [3:0] rc_last;
  logic rc_done_q;
  logic rc_perr_q;
  logic rc_ferr_q;
  logic [7:0] rc_byte_q;
  frm_state_t fr_st_q;
  logic [7:0] rem_q;
  logic [7:0] bcc_q;
  logic match_q;
  logic bcast_q;
  logic resp_req_q;
  logic accept;
  logic clean;
  logic ev_bad;
  logic ev_len_bad;
  logic ev_end;
  logic ev_bcc_ok;
  tx_state_t tx_st_q;
  logic [15:0] dly_q;
  logic [7:0] tlen_q;
  logic [7:0] tcnt_q;
  logic [7:0] tadr_q;
  logic [7:0] tbcc_q;
  logic [11:0] ts_q;
  logic [3:0] tbits_q;
  logic [3:0] tx_nbits;
  logic [7:0] tbyte;
  logic sending;
  logic load;
  logic tx_miss;
  logic tx_end;
  logic [7:0] fifo_data;
  logic fifo_vld;
  logic [$clog2(FIFO_DEPTH):0] fifo_cnt;

  // Builds one outgoing character, start bit first in bit zero.
  function automatic logic [11:0] char_frame(input logic [7:0] d,
                                             input par_mode_t m);
    if (m == PAR_NONE) begin
      return {3'b111, d, 1'b0};
    end
    return {2'b11, par_bit(d, m), d, 1'b0}; // RQ1 RQ2
  endfunction

  // Three-stage line synchroniser; a level counts once stages two and
  // three agree, which also rejects one-cycle glitches.
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rx_s_q <= LINE_SYNC_RST;
    end else begin
      rx_s_q <= {rx_s_q[1:0], line_rx_i};
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rx_q <= 1'b1;
    end else if (rx_s_q[1] == rx_s_q[2]) begin
      rx_q <= rx_s_q[2];
    end
  end

  // Free-running bit-time divider; the tick paces transmit and delays.
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      bt_cnt_q <= '0;
    end else if (bt_cnt_q >= cfg_i.baud_div - 1'b1) begin
      bt_cnt_q <= '0; // RQ14
    end else begin
      bt_cnt_q <= bt_cnt_q + 1'b1;
    end
  end
  assign tick = (bt_cnt_q == '0);

  // Receive character: sample mid-bit after the start edge.
  assign rc_last = (cfg_i.par == PAR_NONE) ? 4'(DATA_BITS - 1)
                                           : 4'(DATA_BITS);
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rc_st_q <= C_IDLE;
      rc_cnt_q <= '0;
      rc_bit_q <= '0;
      rc_sh_q <= '0;
      rc_done_q <= 1'b0;
      rc_perr_q <= 1'b0;
      rc_ferr_q <= 1'b0;
      rc_byte_q <= '0;
    end else begin
      rc_done_q <= 1'b0;
      unique case (rc_st_q)
        C_IDLE: begin
          if (!rx_q) begin
            rc_cnt_q <= cfg_i.baud_div >> 1;
            rc_st_q <= C_START;
          end
        end
        C_START: begin
          if (rc_cnt_q != '0) begin
            rc_cnt_q <= rc_cnt_q - 1'b1;
          end else if (rx_q) begin
            rc_st_q <= C_IDLE;
          end else begin
            rc_cnt_q <= cfg_i.baud_div - 1'b1;
            rc_bit_q <= '0;
            rc_st_q <= C_BITS;
          end
        end
        C_BITS: begin
          if (rc_cnt_q != '0) begin
            rc_cnt_q <= rc_cnt_q - 1'b1;
          end else begin
            rc_sh_q <= {rx_q, rc_sh_q[8:1]};
            rc_cnt_q <= cfg_i.baud_div - 1'b1;
            rc_bit_q <= rc_bit_q + 1'b1;
            if (rc_bit_q == rc_last) begin
              rc_st_q <= C_STOP;
            end
          end
        end
        C_STOP: begin
          if (rc_cnt_q != '0) begin
            rc_cnt_q <= rc_cnt_q - 1'b1;
          end else begin
            rc_done_q <= 1'b1;
            rc_ferr_q <= !rx_q; // RQ1
            if (cfg_i.par == PAR_NONE) begin
              rc_byte_q <= rc_sh_q[8:1];
              rc_perr_q <= 1'b0;
            end else begin
              rc_byte_q <= rc_sh_q[7:0];
              rc_perr_q <= rc_sh_q[8] != par_bit(rc_sh_q[7:0], cfg_i.par); // RQ2
            end
            rc_st_q <= C_IDLE;
          end
        end
      endcase
      // The own echo is abandoned so no half-heard character outlives a reply.
      if (!line_oe_b_o) begin
        rc_st_q <= C_IDLE; // RQ11
      end
    end
  end

  // Own transmission is not heard back; received events are decoded here.
  always_comb begin
    accept = rc_done_q && line_oe_b_o; // RQ11
    clean = accept && !rc_perr_q && !rc_ferr_q;
    ev_bad = accept && !clean && (fr_st_q != F_HUNT); // RQ20
    ev_len_bad = clean && (fr_st_q == F_LEN) && (rc_byte_q < LEN_OVERHEAD);
    ev_end = clean && (fr_st_q == F_BCC);
    ev_bcc_ok = ev_end && (rc_byte_q == bcc_q); // RQ17
  end

  // Deframer: walks the telegram and keeps the running XOR.
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      fr_st_q <= F_HUNT;
      rem_q <= '0;
      bcc_q <= '0;
      rx_addr_o <= '0;
      match_q <= 1'b0;
      bcast_q <= 1'b0;
      rx_data_o <= '0;
      rx_vld_o <= 1'b0;
      resp_req_q <= 1'b0;
    end else begin
      rx_vld_o <= 1'b0;
      resp_req_q <= 1'b0;
      if (ev_bad || ev_len_bad) begin
        fr_st_q <= F_HUNT; // RQ20
      end else if (clean) begin
        unique case (fr_st_q)
          F_HUNT: begin
            if (rc_byte_q == FRAME_START_CHAR) begin
              bcc_q <= rc_byte_q; // RQ3 RQ17
              fr_st_q <= F_LEN;
            end
          end
          F_LEN: begin
            rem_q <= rc_byte_q; // RQ5 RQ6 RQ13
            bcc_q <= bcc_q ^ rc_byte_q;
            fr_st_q <= F_ADDR;
          end
          F_ADDR: begin
            rx_addr_o <= rc_byte_q;
            match_q <= rc_byte_q[ADDR_FMT_BIT] &&
                       (rc_byte_q[6:0] == cfg_i.node ||
                        rc_byte_q[6:0] == BCAST_NODE); // RQ7 RQ8 RQ19
            bcast_q <= rc_byte_q[6:0] == BCAST_NODE; // RQ8
            rem_q <= rem_q - 1'b1;
            bcc_q <= bcc_q ^ rc_byte_q;
            fr_st_q <= (rem_q == LEN_OVERHEAD) ? F_BCC : F_DATA; // RQ4
          end
          F_DATA: begin
            if (match_q) begin
              rx_data_o <= rc_byte_q; // RQ18
              rx_vld_o <= 1'b1;
            end
            rem_q <= rem_q - 1'b1;
            bcc_q <= bcc_q ^ rc_byte_q;
            if (rem_q == LEN_OVERHEAD) begin
              fr_st_q <= F_BCC;
            end
          end
          F_BCC: begin
            fr_st_q <= F_HUNT;
            resp_req_q <= ev_bcc_ok && match_q && !bcast_q; // RQ10 RQ19
          end
          default: fr_st_q <= F_HUNT;
        endcase
      end
    end
  end

  property p_bad_char_drops;
    @(posedge mclk_i) disable iff (!rst_b_i)
    (accept && rc_perr_q && fr_st_q != F_HUNT) |=>
      (fr_st_q == F_HUNT && !resp_req_q && stat_o.par_err);
  endproperty
  a_bad_char_drops: assert property (p_bad_char_drops) // RQ20
    else $error("parity error did not drop the telegram");

  property p_no_bcast_reply;
    @(posedge mclk_i) disable iff (!rst_b_i)
    resp_req_q |-> (match_q && !bcast_q && rx_addr_o[ADDR_FMT_BIT]);
  endproperty
  a_no_bcast_reply: assert property (p_no_bcast_reply) // RQ19
    else $error("response requested for foreign or broadcast telegram");

  // Response data waits in the buffer; the user is stalled when it fills.
  byte_fifo #(
    .WIDTH(FIFO_WIDTH),
    .DEPTH(FIFO_DEPTH)
  ) u_resp_fifo (
    .mclk_i(mclk_i),
    .rst_b_i(rst_b_i),
    .in_data_i(tx_data_i),
    .in_valid_i(tx_vld_i),
    .in_ready_o(tx_rdy_o),
    .out_data_o(fifo_data),
    .out_valid_o(fifo_vld),
    .out_ready_i(load && tx_st_q == T_DAT),
    .count_o(fifo_cnt)
  );

  // Byte to send for the current telegram position.
  always_comb begin
    sending = tx_st_q inside {T_STX, T_LEN, T_ADR, T_DAT, T_BCC};
    load = tick && (tbits_q == '0) && sending;
    tx_miss = (tx_st_q == T_WAIT) && tick && (dly_q >= cfg_i.max_dly);
    tx_end = (tx_st_q == T_DRAIN) && tick && (tbits_q == '0);
    tx_nbits = 4'(CHAR_BITS) - {3'b000, cfg_i.par == PAR_NONE}
             + {3'b000, cfg_i.stop2}; // RQ14
    unique case (tx_st_q)
      T_STX: tbyte = FRAME_START_CHAR; // RQ3
      T_LEN: tbyte = tlen_q + LEN_OVERHEAD; // RQ5
      T_ADR: tbyte = tadr_q; // RQ9
      T_DAT: tbyte = fifo_data; // RQ18
      T_BCC: tbyte = tbcc_q; // RQ17
      T_IDLE, T_WAIT, T_DRAIN: tbyte = '0;
    endcase
  end

  // Response sequencer with turnaround and timeout counting.
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tx_st_q <= T_IDLE;
      dly_q <= '0;
      tlen_q <= '0;
      tcnt_q <= '0;
      tadr_q <= '0;
      tbcc_q <= '0;
    end else begin
      if (load) begin
        tbcc_q <= (tx_st_q == T_STX) ? tbyte : tbcc_q ^ tbyte; // RQ17
      end
      unique case (tx_st_q)
        T_IDLE: begin
          if (resp_req_q) begin
            dly_q <= '0; // RQ10
            tlen_q <= resp_len_i;
            tadr_q <= rx_addr_o; // RQ9
            tx_st_q <= T_WAIT;
          end
        end
        T_WAIT: begin
          if (tx_miss) begin
            tx_st_q <= T_IDLE; // RQ16
          end else if (tick) begin
            if (dly_q >= cfg_i.min_dly &&
                fifo_cnt >= ($clog2(FIFO_DEPTH)+1)'(tlen_q)) begin
              tx_st_q <= T_STX; // RQ15
            end else begin
              dly_q <= dly_q + 1'b1;
            end
          end
        end
        T_STX: if (load) tx_st_q <= T_LEN; // RQ4
        T_LEN: begin
          if (load) begin
            tcnt_q <= tlen_q;
            tx_st_q <= T_ADR;
          end
        end
        T_ADR: if (load) tx_st_q <= (tlen_q == '0) ? T_BCC : T_DAT;
        T_DAT: begin
          if (load) begin
            tcnt_q <= tcnt_q - 1'b1;
            if (tcnt_q == 8'h01) begin
              tx_st_q <= T_BCC;
            end
          end
        end
        T_BCC: if (load) tx_st_q <= T_DRAIN;
        T_DRAIN: if (tx_end) tx_st_q <= T_IDLE;
      endcase
    end
  end

  // Character shifter; bit zero is the level on the line.
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ts_q <= TX_IDLE_CHAR;
      tbits_q <= '0;
    end else if (load) begin
      ts_q <= char_frame(tbyte, cfg_i.par); // RQ1
      tbits_q <= tx_nbits - 4'h1; // RQ1
    end else if (tick && tbits_q != '0) begin
      ts_q <= {1'b1, ts_q[11:1]};
      tbits_q <= tbits_q - 1'b1;
    end
  end
  assign line_tx_o = ts_q[0];

  // Driver enabled from the start of the response until its last stop bit.
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      line_oe_b_o <= 1'b1;
    end else begin
      line_oe_b_o <= !(sending || tx_st_q == T_DRAIN); // RQ11
    end
  end

  // Status pulses, one cycle each.
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      stat_o <= '0;
    end else begin
      stat_o.frame_ok <= ev_bcc_ok && match_q;
      stat_o.bcast <= ev_bcc_ok && match_q && bcast_q;
      stat_o.par_err <= ev_bad && rc_perr_q; // RQ20
      stat_o.frm_err <= ev_bad && rc_ferr_q;
      stat_o.len_err <= ev_len_bad;
      stat_o.bcc_err <= ev_end && !ev_bcc_ok && match_q; // RQ20
      stat_o.resp_sent <= tx_end;
      stat_o.resp_missed <= tx_miss; // RQ16
    end
  end

  property p_drive_only_sending;
    @(posedge mclk_i) disable iff (!rst_b_i)
    !line_oe_b_o |-> $past(sending || tx_st_q == T_DRAIN);
  endproperty
  a_drive_only_sending: assert property (p_drive_only_sending) // RQ11
    else $error("line driven outside a response");

  property p_idle_line_high;
    @(posedge mclk_i) disable iff (!rst_b_i)
    line_oe_b_o |-> (line_tx_o && tbits_q == '0);
  endproperty
  a_idle_line_high: assert property (p_idle_line_high) // RQ11
    else $error("character in flight while driver is off");

  property p_reply_needs_request;
    @(posedge mclk_i) disable iff (!rst_b_i)
    (tx_st_q == T_WAIT && $past(tx_st_q) == T_IDLE) |-> $past(resp_req_q);
  endproperty
  a_reply_needs_request: assert property (p_reply_needs_request) // RQ10
    else $error("response started without an addressed request");

  property p_start_char_first;
    @(posedge mclk_i) disable iff (!rst_b_i)
    (load && tx_st_q == T_STX) |=>
      (ts_q[8:1] == FRAME_START_CHAR && !ts_q[0] && tx_st_q == T_LEN);
  endproperty
  a_start_char_first: assert property (p_start_char_first) // RQ3
    else $error("telegram did not open with the start character");

  property p_len_byte;
    @(posedge mclk_i) disable iff (!rst_b_i)
    (load && tx_st_q == T_LEN) |=> (ts_q[8:1] == tlen_q + LEN_OVERHEAD);
  endproperty
  a_len_byte: assert property (p_len_byte) // RQ5
    else $error("length byte is not data count plus two");

  property p_addr_echo;
    @(posedge mclk_i) disable iff (!rst_b_i)
    (load && tx_st_q == T_ADR) |=> (ts_q[8:1] == tadr_q && !ts_q[0]);
  endproperty
  a_addr_echo: assert property (p_addr_echo) // RQ9
    else $error("response address differs from request address");

  property p_even_parity;
    @(posedge mclk_i) disable iff (!rst_b_i)
    (load && cfg_i.par == PAR_EVEN) |=> (^ts_q[9:1] == 1'b0);
  endproperty
  a_even_parity: assert property (p_even_parity) // RQ2
    else $error("outgoing character has odd ones count");

  property p_min_delay;
    @(posedge mclk_i) disable iff (!rst_b_i)
    (tx_st_q == T_STX && $past(tx_st_q) == T_WAIT) |->
      ($past(dly_q) >= $past(cfg_i.min_dly));
  endproperty
  a_min_delay: assert property (p_min_delay) // RQ15
    else $error("response started before the minimum delay");

  property p_max_delay;
    @(posedge mclk_i) disable iff (!rst_b_i)
    (tx_st_q == T_WAIT) |-> (dly_q <= cfg_i.max_dly);
  endproperty
  a_max_delay: assert property (p_max_delay) // RQ16
    else $error("turnaround wait ran past the maximum delay");

endmodule
`default_nettype wire

// *** bench/line_master.sv ***
`timescale 1ns/1ps
`default_nettype none
// Single bus master: the only node that starts telegrams.
module line_master #(
  parameter int BD = 8
) (
  input wire logic mclk_i,
  input wire logic line_i,
  output logic line_o
);
  // Biased termination holds the released line high.
  initial line_o = 1'b1;

  // One character, LSB first; bad flips the parity bit.
  task automatic send_char(input logic [7:0] d, input logic bad);
    logic [10:0] f;
    f = {1'b1, (^d) ^ bad, d, 1'b0};
    for (int i = 0; i < 11; i++) begin
      @(negedge mclk_i);
      line_o = f[i];
      repeat (BD - 1) @(negedge mclk_i);
    end
  endtask

  // Whole request; bad_at names a character sent with wrong parity.
  task automatic send_tel(input logic [7:0] adr, input logic [7:0] d[$],
                          input int bad_at, input logic [7:0] flip);
    logic [7:0] t[$];
    logic [7:0] x;
    t = {8'h02, 8'(d.size() + 2), adr};
    t = {t, d};
    x = 8'h00;
    foreach (t[i]) x ^= t[i];
    t.push_back(x ^ flip);
    foreach (t[i]) send_char(t[i], i == bad_at);
  endtask

  // Samples one character mid-bit; ok drops on a framing or parity fault.
  task automatic recv_char(output logic [7:0] d, inout logic ok);
    logic [10:0] f;
    wait (line_i === 1'b0);
    repeat (BD / 2) @(negedge mclk_i);
    for (int i = 0; i < 11; i++) begin
      f[i] = line_i;
      if (i < 10) repeat (BD) @(negedge mclk_i);
    end
    d = f[8:1];
    if (f[0] !== 1'b0 || f[10] !== 1'b1 || (^f[9:1]) !== 1'b0) ok = 1'b0;
  endtask

  // Whole response; the length byte says how many characters follow.
  task automatic recv_tel(output logic [7:0] t[$], output logic ok);
    logic [7:0] b;
    t = {};
    ok = 1'b1;
    for (int i = 0; i < 2; i++) begin
      recv_char(b, ok);
      t.push_back(b);
    end
    repeat (t[1]) begin
      recv_char(b, ok);
      t.push_back(b);
    end
  endtask
endmodule
`default_nettype wire

// *** bench/drive_serial_telegram_follower_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module drive_serial_telegram_follower_tb;
  import serial_follower_pkg::*;
  localparam int BD = 8;
  localparam int MIN_DLY = 6;
  localparam int MAX_DLY = 40;
  localparam int OK = 7, BC = 6, PE = 5, LE = 3, CE = 2, SENT = 1, MISS = 0;
  logic mclk_i = 1'b0;
  logic rst_b_i = 1'b0;
  cfg_t cfg_i;
  logic line_tx_o, line_oe_b_o, m_line, line, rx_vld_o, tx_rdy_o;
  logic [7:0] rx_data_o, rx_addr_o, resp_len_i = 8'h00, tx_data_i = 8'h00;
  logic tx_vld_i = 1'b0;
  stat_t stat_o;
  int n_mismatch = 0, comparisons = 0, n_oe = 0;
  int n_st[8];
  logic [7:0] rxq[$];

  always #2 mclk_i = ~mclk_i;
  // The follower owns the line only while its enable is low.
  assign line = line_oe_b_o ? m_line : line_tx_o;

  serial_follower u_serial_follower (.mclk_i(mclk_i), .rst_b_i(rst_b_i),
    .cfg_i(cfg_i), .line_rx_i(line), .line_tx_o(line_tx_o),
    .line_oe_b_o(line_oe_b_o), .rx_data_o(rx_data_o), .rx_vld_o(rx_vld_o),
    .rx_addr_o(rx_addr_o), .stat_o(stat_o), .resp_len_i(resp_len_i),
    .tx_data_i(tx_data_i), .tx_vld_i(tx_vld_i), .tx_rdy_o(tx_rdy_o));
  line_master #(.BD(BD)) u_line_master (.mclk_i(mclk_i), .line_i(line),
    .line_o(m_line));

  // Tallies status pulses, driver-on cycles and delivered bytes.
  always @(posedge mclk_i) begin
    for (int k = 0; k < 8; k++)
      if (stat_o[k] === 1'b1) n_st[k]++;
    if (line_oe_b_o === 1'b0) n_oe++;
    if (rx_vld_o === 1'b1) rxq.push_back(rx_data_o);
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask

  task automatic clr();
    n_oe = 0;
    foreach (n_st[k]) n_st[k] = 0;
    rxq = {};
    resp_len_i = 8'h00;
  endtask

  task automatic quiet();
    repeat (MAX_DLY * BD) @(negedge mclk_i);
  endtask

  // Addressed request with the answer queued first; checks data,
  // turnaround, echoed address and the buffer filling and draining.
  task automatic serve(input logic [7:0] d[$], input logic [7:0] r[$]);
    logic [7:0] t[$];
    logic [7:0] x;
    logic ok;
    int w;
    clr();
    resp_len_i = 8'(r.size());
    tx_vld_i = 1'b1;
    foreach (r[i]) begin
      tx_data_i = r[i];
      @(posedge mclk_i);
      while (tx_rdy_o !== 1'b1) @(posedge mclk_i);
      @(negedge mclk_i);
    end
    tx_vld_i = 1'b0;
    check(tx_rdy_o, r.size() < FIFO_DEPTH);
    u_line_master.send_tel(8'h85, d, -1, 8'h00);
    w = 0;
    while (line_oe_b_o !== 1'b0 && w < 4000) begin
      @(negedge mclk_i);
      w++;
    end
    check(w >= MIN_DLY * BD && w < MAX_DLY * BD, 1);
    u_line_master.recv_tel(t, ok);
    repeat (2 * BD) @(negedge mclk_i);
    check(ok, 1);
    check(rxq.size(), d.size());
    foreach (d[i]) check(rxq[i], d[i]);
    check(n_st[OK], 1);
    check(rx_addr_o, 8'h85);
    check(t.size(), r.size() + 4);
    check(t[0], 8'h02);
    check(t[1], r.size() + 2);
    check(t[2], 8'h85);
    x = 8'h00;
    foreach (t[i]) x ^= t[i];
    check(x, 0);
    foreach (r[i]) check(t[i + 3], r[i]);
    check(n_st[SENT], 1);
    check(tx_rdy_o, 1);
  endtask

  // Foreign node and wrong address format both stay silent.
  task automatic t_ignore();
    clr();
    u_line_master.send_tel(8'h86, {8'h01, 8'h03, 8'h04, 8'h05}, -1, 8'h00);
    u_line_master.send_tel(8'h05, {8'h01, 8'h03, 8'h04, 8'h05}, -1, 8'h00);
    quiet();
    check(rxq.size(), 0);
    check(n_st[OK], 0);
    check(n_oe, 0);
    $display("test ignore done");
  endtask

  // Broadcast delivers data but gets no answer.
  task automatic t_bcast();
    clr();
    u_line_master.send_tel(8'h80, {8'h11, 8'h22, 8'h33, 8'h44}, -1, 8'h00);
    quiet();
    check(rxq.size(), 4);
    check(n_st[BC], 1);
    check(n_st[OK], 1);
    check(n_oe, 0);
    $display("test broadcast done");
  endtask

  // Parity fault, bad check byte and too short a length: all flagged,
  // none answered.
  task automatic t_errors();
    clr();
    u_line_master.send_tel(8'h85, {8'h11, 8'h22, 8'h33, 8'h44}, 3, 8'h00);
    repeat (20 * BD) @(negedge mclk_i);
    u_line_master.send_tel(8'h85, {8'h11, 8'h22, 8'h33, 8'h44}, -1, 8'h01);
    u_line_master.send_char(8'h02, 1'b0);
    u_line_master.send_char(8'h01, 1'b0);
    quiet();
    check(n_st[PE], 1);
    check(n_st[CE], 1);
    check(n_st[LE], 1);
    check(n_st[OK], 0);
    check(n_oe, 0);
    $display("test errors done");
  endtask

  // Answer data never arrives, so the response is dropped.
  task automatic t_missed();
    clr();
    resp_len_i = 8'h04;
    u_line_master.send_tel(8'h85, {8'h51, 8'h52, 8'h53, 8'h54}, -1, 8'h00);
    repeat ((MAX_DLY + 4) * BD) @(negedge mclk_i);
    check(n_st[MISS], 1);
    check(n_oe, 0);
    $display("test missed done");
  endtask

  // Process telegram with a four-byte answer.
  task automatic t_short();
    serve({8'h11, 8'h22, 8'h33, 8'h44}, {8'hA0, 8'hA1, 8'hA2, 8'hA3});
    $display("test short done");
  endtask

  // Parameter telegram; a full buffer of answer bytes sent with two stops.
  task automatic t_long();
    logic [7:0] d[$];
    logic [7:0] r[$];
    for (int i = 0; i < 16; i++) begin
      if (i < 12) d.push_back(8'(8'h30 + i));
      r.push_back(8'(8'hC0 + i));
    end
    cfg_i.stop2 = 1'b1;
    serve(d, r);
    cfg_i.stop2 = 1'b0;
    $display("test long done");
  endtask

  task automatic complete_run();
    $display("comparisons=%0d mismatches=%0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Reset for sixteen cycles, then the scenarios in turn.
  initial begin
    cfg_i = '{baud_div: DIV_W'(BD), node: 7'h05, par: PAR_EVEN,
              stop2: 1'b0, min_dly: 16'(MIN_DLY), max_dly: 16'(MAX_DLY)};
    repeat (16) @(negedge mclk_i);
    rst_b_i = 1'b1;
    repeat (4) @(negedge mclk_i);
    t_ignore();
    t_bcast();
    t_errors();
    t_missed();
    t_short();
    t_long();
    complete_run();
  end

  // Cuts a hang short well past the expected run length.
  initial begin
    repeat (80000) @(posedge mclk_i);
    n_mismatch++;
    complete_run();
  end
endmodule
`default_nettype wire
